// ---- src/fid_pkg.sv ----
// Shared types and constants for the 14-bit instruction decoder and sequencer.
// Assumes one core clock per oscillator period and a synchronous register file.
package fid_pkg;

    localparam int INSTR_W = 14;
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int STK_D = 8;
    localparam int STK_AW = 3;
    // Four oscillator periods make one instruction cycle
    localparam int QUAD_N = 4;

    localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
    localparam logic [6:0] CTL_RETURN = 7'h08;
    localparam logic [6:0] CTL_RETFIE = 7'h09;
    localparam logic [6:0] CTL_SLEEP = 7'h63;
    localparam logic [6:0] CTL_CLRWDT = 7'h64;

    // Field positions of the instruction word
    localparam int F_LSB = 0;
    localparam int D_BIT = 7;
    localparam int B_LSB = 7;
    localparam int K_LSB = 0;

    typedef enum logic [1:0] {
        GRP_BYTE = 2'b00,
        GRP_BIT = 2'b01,
        GRP_LIT = 2'b10
    } fid_grp_e;

    typedef enum logic [1:0] {
        PH_DEC = 2'b00,
        PH_READ = 2'b01,
        PH_EXEC = 2'b10,
        PH_WRITE = 2'b11
    } fid_phase_e;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
        OP_XOR = 4'h4, OP_COM = 4'h5, OP_DEC = 4'h6, OP_INC = 4'h7,
        OP_PASSA = 4'h8, OP_PASSB = 4'h9, OP_ZERO = 4'hA, OP_RL = 4'hB,
        OP_RR = 4'hC, OP_SWAP = 4'hD, OP_BCLR = 4'hE, OP_BSET = 4'hF
    } fid_alu_e;

    typedef enum logic [1:0] {
        SK_NONE = 2'b00,
        SK_ZERO = 2'b01,
        SK_BITCLR = 2'b10,
        SK_BITSET = 2'b11
    } fid_skip_e;

    typedef enum logic [1:0] {
        BR_NONE = 2'b00,
        BR_GOTO = 2'b01,
        BR_CALL = 2'b10,
        BR_RET = 2'b11
    } fid_br_e;

    typedef struct packed {
        fid_grp_e grp;
        fid_alu_e op;
        logic uses_f;
        logic wr_f;
        logic wr_w;
        logic lit;
        logic fl_c;
        logic fl_dc;
        logic fl_z;
        fid_skip_e skip;
        fid_br_e br;
        logic sleep;
        logic clrwdt;
    } fid_dec_s;

    typedef struct packed {
        fid_phase_e q;
        logic [PC_W-1:0] pc;
        logic [INSTR_W-1:0] ir;
        logic [DATA_W-1:0] opnd;
        logic [DATA_W-1:0] res;
        logic rc;
        logic rdc;
        logic rz;
        logic rskip;
        logic [DATA_W-1:0] w;
        logic c;
        logic dc;
        logic z;
        logic timeout_flag;
        logic powerdown_flag;
        logic [STK_AW-1:0] sp;
        logic [STK_D-1:0][PC_W-1:0] stack;
    } fid_state_s;

    localparam fid_state_s ST_RST = '{q: PH_DEC, pc: '0, ir: NOP_WORD, opnd: '0, res: '0,
                                      rc: 1'b0, rdc: 1'b0, rz: 1'b0, rskip: 1'b0, w: '0,
                                      c: 1'b0, dc: 1'b0, z: 1'b0, timeout_flag: 1'b1,
                                      powerdown_flag: 1'b1, sp: '0, stack: '0};

endpackage

// ---- src/fid_alu.sv ----
// Combinational 8-bit arithmetic and logic unit of the core.
// Assumes operand a is the file or literal value and b the working register.
`timescale 1ns/1ps

module fid_alu (
    input wire fid_pkg::fid_alu_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic [2:0] bsel,
    output logic [7:0] y,
    output logic cout,
    output logic dcout,
    output logic zout
);

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] mask;

    always_comb begin
        mask = 8'h01 << bsel;
        sum = 9'h000;
        nib = 5'h00;
        y = a;
        cout = cin;
        dcout = 1'b0;
        unique case (op)
            fid_pkg::OP_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                y = sum[7:0];
                cout = sum[8];
                dcout = nib[4];
            end
            fid_pkg::OP_SUB: begin
                // Carry reads as not-borrow
                sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
                nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
                y = sum[7:0];
                cout = sum[8];
                dcout = nib[4];
            end
            fid_pkg::OP_AND: y = a & b;
            fid_pkg::OP_IOR: y = a | b;
            fid_pkg::OP_XOR: y = a ^ b;
            fid_pkg::OP_COM: y = ~a;
            fid_pkg::OP_DEC: y = a - 8'h01;
            fid_pkg::OP_INC: y = a + 8'h01;
            fid_pkg::OP_PASSA: y = a;
            fid_pkg::OP_PASSB: y = b;
            fid_pkg::OP_ZERO: y = 8'h00;
            fid_pkg::OP_RL: begin
                y = {a[6:0], cin};
                cout = a[7];
            end
            fid_pkg::OP_RR: begin
                y = {cin, a[7:1]};
                cout = a[0];
            end
            fid_pkg::OP_SWAP: y = {a[3:0], a[7:4]};
            fid_pkg::OP_BCLR: y = a & ~mask;
            fid_pkg::OP_BSET: y = a | mask;
        endcase
        zout = (y == 8'h00);
    end

endmodule

// ---- src/fid_core.sv ----
// Instruction decoder and four-phase sequencer of an 8-bit core.
// Assumes instruction memory answers fetch_addr within the cycle and the register
// file returns file_rd_data in the clock after file_rd_en.
`timescale 1ns/1ps

// Function
// RL1: Every instruction is one 14-bit word of opcode plus operand fields.
// RL2: Each word falls into byte, bit, or literal/control group, never two.
// RL3: Byte operations store to W when d is 0, to the file when 1.
// RL4: File address operand spans 0x00 to 0x7F in the selected bank.
// RL5: Bit operations act on one bit chosen by the bit field.
// RL6: Literals are 8 bits for data, 11 bits for branch targets.
// RL7: Don't-care bits never change how a word decodes.
// RL8: One instruction cycle lasts four oscillator periods.
// RL9: One cycle per instruction; taken skip or PC change adds a NOP cycle.
// RL10: Every file operand is read, modified, then stored, even pure writes.
// RL11: Clearing the port still reads it, clearing its pending change condition.
// RL12: Port read-modify-write takes its value from the pin levels.
// RL13: Writing the timer count clears the prescaler when assigned to it.
// RL14: The flush cycle discards the prefetch and fetches the new PC.
// RL15: Carry, digit carry and zero change only for defining ops, at write.
module fid_core #(
    parameter logic [6:0] PORT_ADDR = 7'h05,
    parameter logic [6:0] TIMER_ADDR = 7'h01
) (
    input wire logic clk,
    input wire logic rst,
    output logic [fid_pkg::PC_W-1:0] fetch_addr,
    input wire logic [fid_pkg::INSTR_W-1:0] instr_data,
    output logic [fid_pkg::FADDR_W-1:0] file_addr,
    output logic file_rd_en,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    input wire logic [7:0] pin_level,
    input wire logic prescaler_on_timer,
    output logic prescaler_clr,
    output fid_pkg::fid_grp_e instr_group,
    output logic cycle_end,
    output logic flush,
    output logic sleep_req,
    output logic wdt_clear,
    output logic [7:0] w_reg,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic timeout_flag,
    output logic powerdown_flag
);

    if (PORT_ADDR == TIMER_ADDR) begin : g_chk_addr
        $error("Port and timer addresses must differ");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic fid_pkg::fid_dec_s decode(input logic [13:0] ir);
        fid_pkg::fid_dec_s d;
        d = '0;
        d.grp = fid_pkg::GRP_BYTE;
        d.op = fid_pkg::OP_PASSA;
        d.skip = fid_pkg::SK_NONE;
        d.br = fid_pkg::BR_NONE;
        // Only the leading bits pick the group [RL1] [RL2]
        unique case (ir[13:12])
            2'b00: begin
                d.uses_f = 1'b1;
                d.wr_f = ir[fid_pkg::D_BIT];  // [RL3]
                d.wr_w = ~ir[fid_pkg::D_BIT];  // [RL3]
                d.fl_z = 1'b1;
                unique case (ir[11:8])
                    4'h0: begin
                        d.op = fid_pkg::OP_PASSB;
                        d.fl_z = 1'b0;
                        d.wr_w = 1'b0;
                        if (!ir[fid_pkg::D_BIT]) begin
                            d.uses_f = 1'b0;
                            d.br = (ir[6:0] == fid_pkg::CTL_RETURN || ir[6:0] == fid_pkg::CTL_RETFIE)
                                ? fid_pkg::BR_RET : fid_pkg::BR_NONE;
                            d.sleep = (ir[6:0] == fid_pkg::CTL_SLEEP);
                            d.clrwdt = (ir[6:0] == fid_pkg::CTL_CLRWDT);
                        end
                    end
                    4'h1: begin
                        d.op = fid_pkg::OP_ZERO;
                        d.uses_f = ir[fid_pkg::D_BIT];  // Clear-W ignores f [RL7]
                    end
                    4'h2: {d.op, d.fl_c, d.fl_dc} = {fid_pkg::OP_SUB, 2'b11};
                    4'h3: d.op = fid_pkg::OP_DEC;
                    4'h4: d.op = fid_pkg::OP_IOR;
                    4'h5: d.op = fid_pkg::OP_AND;
                    4'h6: d.op = fid_pkg::OP_XOR;
                    4'h7: {d.op, d.fl_c, d.fl_dc} = {fid_pkg::OP_ADD, 2'b11};
                    4'h8: d.op = fid_pkg::OP_PASSA;
                    4'h9: d.op = fid_pkg::OP_COM;
                    4'hA: d.op = fid_pkg::OP_INC;
                    4'hB: {d.op, d.fl_z, d.skip} = {fid_pkg::OP_DEC, 1'b0, fid_pkg::SK_ZERO};
                    4'hC: {d.op, d.fl_z, d.fl_c} = {fid_pkg::OP_RR, 2'b01};
                    4'hD: {d.op, d.fl_z, d.fl_c} = {fid_pkg::OP_RL, 2'b01};
                    4'hE: {d.op, d.fl_z} = {fid_pkg::OP_SWAP, 1'b0};
                    4'hF: {d.op, d.fl_z, d.skip} = {fid_pkg::OP_INC, 1'b0, fid_pkg::SK_ZERO};
                endcase
            end
            2'b01: begin
                d.grp = fid_pkg::GRP_BIT;
                d.uses_f = 1'b1;
                d.wr_f = ~ir[11];
                d.op = ir[11] ? fid_pkg::OP_PASSA : (ir[10] ? fid_pkg::OP_BSET : fid_pkg::OP_BCLR);  // [RL5]
                d.skip = ir[11] ? (ir[10] ? fid_pkg::SK_BITSET : fid_pkg::SK_BITCLR) : fid_pkg::SK_NONE;
            end
            2'b10: begin
                d.grp = fid_pkg::GRP_LIT;
                d.br = ir[11] ? fid_pkg::BR_GOTO : fid_pkg::BR_CALL;  // 11-bit target [RL6]
            end
            2'b11: begin
                d.grp = fid_pkg::GRP_LIT;
                d.lit = 1'b1;  // 8-bit literal [RL6]
                d.wr_w = 1'b1;
                d.fl_z = 1'b1;
                // Low bits marked x are left out of every match [RL7]
                casez (ir[11:8])
                    4'b00??: d.fl_z = 1'b0;
                    4'b01??: {d.fl_z, d.br} = {1'b0, fid_pkg::BR_RET};
                    4'b1000: d.op = fid_pkg::OP_IOR;
                    4'b1001: d.op = fid_pkg::OP_AND;
                    4'b1010: d.op = fid_pkg::OP_XOR;
                    4'b110?: {d.op, d.fl_c, d.fl_dc} = {fid_pkg::OP_SUB, 2'b11};
                    4'b111?: {d.op, d.fl_c, d.fl_dc} = {fid_pkg::OP_ADD, 2'b11};
                    default: {d.wr_w, d.fl_z} = 2'b00;
                endcase
            end
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    fid_pkg::fid_state_s st;
    fid_pkg::fid_state_s next_st;
    fid_pkg::fid_dec_s dec;
    logic [7:0] rd_val;
    logic [7:0] alu_a;
    logic [7:0] alu_y;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic taken;

    assign dec = decode(st.ir);
    // Port reads see the pins, not the output latch [RL12]
    assign rd_val = (st.ir[6:0] == PORT_ADDR) ? pin_level : file_rd_data;
    assign alu_a = dec.lit ? st.ir[7:0] : rd_val;
    assign taken = st.rskip || (dec.br != fid_pkg::BR_NONE);  // [RL9]

    fid_alu u_alu (
        .op(dec.op),
        .a(alu_a),
        .b(st.w),
        .cin(st.c),
        .bsel(st.ir[9:7]),
        .y(alu_y),
        .cout(alu_c),
        .dcout(alu_dc),
        .zout(alu_z)
    );

    always_comb begin
        next_st = st;
        unique case (st.q)  // [RL8]
            fid_pkg::PH_DEC: next_st.q = fid_pkg::PH_READ;
            fid_pkg::PH_READ: next_st.q = fid_pkg::PH_EXEC;
            fid_pkg::PH_EXEC: begin
                next_st.q = fid_pkg::PH_WRITE;
                next_st.opnd = alu_a;  // [RL10]
                next_st.res = alu_y;
                next_st.rc = alu_c;
                next_st.rdc = alu_dc;
                next_st.rz = alu_z;
                unique case (dec.skip)
                    fid_pkg::SK_NONE: next_st.rskip = 1'b0;
                    fid_pkg::SK_ZERO: next_st.rskip = alu_z;
                    fid_pkg::SK_BITCLR: next_st.rskip = ~alu_a[st.ir[9:7]];
                    fid_pkg::SK_BITSET: next_st.rskip = alu_a[st.ir[9:7]];
                endcase
            end
            fid_pkg::PH_WRITE: begin
                next_st.q = fid_pkg::PH_DEC;
                next_st.rskip = 1'b0;
                if (dec.wr_w) begin
                    next_st.w = st.res;  // [RL3]
                end
                // Flags land together with the result [RL15]
                if (dec.fl_c) begin
                    next_st.c = st.rc;
                end
                if (dec.fl_dc) begin
                    next_st.dc = st.rdc;
                end
                if (dec.fl_z) begin
                    next_st.z = st.rz;
                end
                if (dec.clrwdt) begin
                    {next_st.timeout_flag, next_st.powerdown_flag} = 2'b11;
                end
                if (dec.sleep) begin
                    {next_st.timeout_flag, next_st.powerdown_flag} = 2'b10;
                end
                unique case (dec.br)
                    fid_pkg::BR_NONE: next_st.pc = st.pc + 11'h001;
                    fid_pkg::BR_GOTO: next_st.pc = st.ir[10:0];
                    fid_pkg::BR_CALL: begin
                        // Oldest return address is overwritten on overflow
                        next_st.stack[st.sp] = st.pc;
                        next_st.sp = st.sp + 3'h1;
                        next_st.pc = st.ir[10:0];
                    end
                    fid_pkg::BR_RET: begin
                        next_st.sp = st.sp - 3'h1;
                        next_st.pc = st.stack[st.sp - 3'h1];
                    end
                endcase
                // Prefetched word is dropped and replaced by a NOP [RL9] [RL14]
                next_st.ir = taken ? fid_pkg::NOP_WORD : instr_data;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= fid_pkg::ST_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign fetch_addr = st.pc;  // [RL14]
    assign file_addr = st.ir[6:0];  // [RL4]
    // Pure writes such as clear still read first [RL10] [RL11]
    assign file_rd_en = dec.uses_f && (st.q == fid_pkg::PH_READ);
    assign file_wr_en = dec.wr_f && (st.q == fid_pkg::PH_WRITE);
    assign file_wr_data = st.res;
    assign prescaler_clr = file_wr_en && (file_addr == TIMER_ADDR) && prescaler_on_timer;  // [RL13]
    assign instr_group = dec.grp;
    assign cycle_end = (st.q == fid_pkg::PH_WRITE);
    assign flush = cycle_end && taken;
    assign sleep_req = cycle_end && dec.sleep;
    assign wdt_clear = cycle_end && (dec.sleep || dec.clrwdt);
    assign w_reg = st.w;
    assign carry_flag = st.c;
    assign digit_carry_flag = st.dc;
    assign zero_flag = st.z;
    assign timeout_flag = st.timeout_flag;
    assign powerdown_flag = st.powerdown_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_quad;
        st.q == fid_pkg::PH_READ ##1 st.q == fid_pkg::PH_EXEC ##1 st.q == fid_pkg::PH_WRITE
            ##1 st.q == fid_pkg::PH_DEC;
    endsequence
    property p_quad;
        @(posedge clk) disable iff (rst) st.q == fid_pkg::PH_DEC |=> s_quad;
    endproperty
    a_quad: assert property (p_quad) else $error("Cycle is not four phases"); // [RL8]

    property p_rmw;
        @(posedge clk) disable iff (rst) file_wr_en |-> $past(file_rd_en, 2);
    endproperty
    a_rmw: assert property (p_rmw) else $error("File write without prior read"); // [RL10]

    property p_clr_reads;
        @(posedge clk) disable iff (rst)
            (st.q == fid_pkg::PH_READ && st.ir[13:8] == 6'h01 && st.ir[7]) |-> file_rd_en;
    endproperty
    a_clr_reads: assert property (p_clr_reads) else $error("Clear of file skipped its read"); // [RL11]

    property p_dest_w;
        @(posedge clk) disable iff (rst)
            (cycle_end && dec.grp == fid_pkg::GRP_BYTE && !st.ir[7]) |-> !file_wr_en;
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("W destination wrote the file"); // [RL3]

    property p_addr;
        @(posedge clk) disable iff (rst) file_rd_en |-> ##2 (file_wr_en || !dec.wr_f) && file_addr == $past(file_addr, 2);
    endproperty
    a_addr: assert property (p_addr) else $error("File address moved within the cycle"); // [RL4]

    property p_bitset;
        @(posedge clk) disable iff (rst)
            (file_wr_en && st.ir[13:10] == 4'h5) |-> file_wr_data == (st.opnd | (8'h01 << st.ir[9:7]));
    endproperty
    a_bitset: assert property (p_bitset) else $error("Bit set touched the wrong bit"); // [RL5]

    sequence s_flush(logic [10:0] tgt);
        st.ir == fid_pkg::NOP_WORD && st.pc == tgt ##4 st.pc == tgt + 11'h001;
    endsequence
    property p_goto;
        logic [10:0] t;
        @(posedge clk) disable iff (rst)
            (cycle_end && dec.br == fid_pkg::BR_GOTO, t = st.ir[10:0]) |=> s_flush(t);
    endproperty
    a_goto: assert property (p_goto) else $error("Jump did not flush and refetch"); // [RL9] [RL14]

    property p_skip;
        @(posedge clk) disable iff (rst) (cycle_end && st.rskip) |=> st.ir == fid_pkg::NOP_WORD;
    endproperty
    a_skip: assert property (p_skip) else $error("Taken skip kept the prefetch"); // [RL9]

    property p_port;
        @(posedge clk) disable iff (rst)
            (st.q == fid_pkg::PH_EXEC && dec.uses_f && st.ir[6:0] == PORT_ADDR) |=> st.opnd == $past(pin_level);
    endproperty
    a_port: assert property (p_port) else $error("Port operand not from pins"); // [RL12]

    property p_tmr;
        @(posedge clk) disable iff (rst)
            (cycle_end && dec.wr_f && st.ir[6:0] == TIMER_ADDR) |-> prescaler_clr == prescaler_on_timer;
    endproperty
    a_tmr: assert property (p_tmr) else $error("Timer write left prescaler"); // [RL13]

    property p_flag_time;
        @(posedge clk) disable iff (rst) (st.z != $past(st.z)) |-> $past(st.q) == fid_pkg::PH_WRITE;
    endproperty
    a_flag_time: assert property (p_flag_time) else $error("Zero flag changed off the write phase"); // [RL15]

    property p_movlw;
        @(posedge clk) disable iff (rst) (cycle_end && st.ir[13:10] == 4'hC) |=> st.w == $past(st.ir[7:0]);
    endproperty
    a_movlw: assert property (p_movlw) else $error("Literal not loaded into W"); // [RL6] [RL7]

endmodule

// ---- sim/tb_fourteen_bit_instr_decoder.sv ----
// Self-checking bench for the 14-bit instruction decoder and sequencer.
// Assumes fid_core alone; the bench models program memory and the register file.
`timescale 1ns/1ps

module tb_fourteen_bit_instr_decoder;
    logic clk;
    logic rst;
    logic [fid_pkg::PC_W-1:0] fetch_addr;
    logic [fid_pkg::INSTR_W-1:0] instr_data;
    logic [fid_pkg::FADDR_W-1:0] file_addr;
    logic file_rd_en;
    logic [7:0] file_rd_data;
    logic file_wr_en;
    logic [7:0] file_wr_data;
    logic [7:0] pin_level;
    logic prescaler_on_timer;
    logic prescaler_clr;
    fid_pkg::fid_grp_e instr_group;
    logic cycle_end;
    logic flush;
    logic [7:0] w_reg;
    logic carry_flag;
    logic digit_carry_flag;
    logic zero_flag;
    logic sleep_req;
    logic wdt_clear;
    logic timeout_flag;
    logic powerdown_flag;
    logic [13:0] prog [0:2047];
    logic [7:0] fmem [0:127];
    fid_pkg::fid_grp_e glog [$];
    int errors = 0;
    int compares = 0;
    int n_clk = 0;
    int n_rd, n_wr, n_fl, n_pc, n_prd, n_sl, n_wd;

    fid_core i_fid_core (
        .clk(clk), .rst(rst), .fetch_addr(fetch_addr), .instr_data(instr_data), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data), .pin_level(pin_level), .prescaler_on_timer(prescaler_on_timer),
        .prescaler_clr(prescaler_clr), .instr_group(instr_group), .cycle_end(cycle_end), .flush(flush),
        .sleep_req(sleep_req), .wdt_clear(wdt_clear), .w_reg(w_reg), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag)
    );

    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    assign instr_data = prog[fetch_addr];

    // Stale read data flips so a late sample never matches by luck
    always @(posedge clk) begin
        if (file_rd_en === 1'b1) file_rd_data <= fmem[file_addr];
        else file_rd_data <= ~file_rd_data;
        if (file_wr_en === 1'b1) fmem[file_addr] = file_wr_data;
        n_clk = n_clk + 1;
        if (n_clk > 2000) begin
            errors++;
            test_done();
        end
    end

    // Strobes are one clock wide, so one mid-cycle look each
    always @(negedge clk) begin
        if (rst === 1'b0) begin
            n_rd += (file_rd_en === 1'b1);
            n_wr += (file_wr_en === 1'b1);
            n_fl += (flush === 1'b1);
            n_pc += (prescaler_clr === 1'b1);
            n_prd += (file_rd_en === 1'b1 && file_addr === 7'h05);
            n_sl += (sleep_req === 1'b1);
            n_wd += (wdt_clear === 1'b1);
            if (cycle_end === 1'b1) glog.push_back(instr_group);
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Unused program space reads as no-operation
    task automatic start;
        rst = 1'b1;
        foreach (prog[i]) prog[i] = 14'h0000;
        foreach (fmem[i]) fmem[i] = 8'h00;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        n_rd = 0; n_wr = 0; n_fl = 0; n_pc = 0; n_prd = 0;
        n_sl = 0;
        n_wd = 0;
        glog.delete();
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) begin
            do @(negedge clk); while (cycle_end !== 1'b1);
            @(posedge clk);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_byte;
        fid_pkg::fid_grp_e eg [8] = '{fid_pkg::GRP_BYTE, fid_pkg::GRP_LIT, fid_pkg::GRP_BYTE, fid_pkg::GRP_BYTE,
                                      fid_pkg::GRP_BYTE, fid_pkg::GRP_LIT, fid_pkg::GRP_BYTE, fid_pkg::GRP_BIT};
        start();
        prog[0] = 14'h335A;
        prog[1] = 14'h00A0;
        prog[2] = 14'h0720;
        prog[3] = 14'h07A0;
        prog[4] = 14'h3000;
        prog[5] = 14'h0100;
        prog[6] = 14'h1420;
        prog[7] = 14'h2807;
        wait_cycles(4);
        check("w_add_to_w", w_reg, 16'h00B4);
        check("f_kept", fmem[7'h20], 16'h005A);
        check("dc_add", digit_carry_flag, 16'h0001);
        wait_cycles(1);
        check("f_add_to_f", fmem[7'h20], 16'h000E);
        check("w_kept", w_reg, 16'h00B4);
        check("c_add", carry_flag, 16'h0001);
        wait_cycles(1);
        check("w_literal", w_reg, 16'h0000);
        check("z_untouched", zero_flag, 16'h0000);
        check("c_untouched", carry_flag, 16'h0001);
        wait_cycles(1);
        check("z_clear_w", zero_flag, 16'h0001);
        wait_cycles(1);
        check("f_bit_set", fmem[7'h20], 16'h000F);
        check("reads", n_rd, 16'h0004);
        check("writes", n_wr, 16'h0003);
        check("group_count", glog.size() >= 8, 16'h0001);
        for (int i = 0; i < 8; i++) check("group", glog[i], eg[i]);
    endtask

    task automatic t_bits;
        int gap;
        start();
        fmem[7'h7F] = 8'h0F;
        fmem[7'h21] = 8'hF0;
        prog[0] = 14'h17FF;
        prog[1] = 14'h107F;
        prog[2] = 14'h15A1;
        prog[3] = 14'h13A1;
        prog[4] = 14'h2804;
        wait_cycles(1);
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (cycle_end !== 1'b1 && gap < 20);
        check("cycle_len", gap, 16'h0004);
        wait_cycles(4);
        check("f_top_addr", fmem[7'h7F], 16'h008E);
        check("f_bits", fmem[7'h21], 16'h0078);
    endtask

    task automatic t_branch;
        start();
        fmem[7'h22] = 8'h01;
        prog[0] = 14'h2C05;
        prog[1] = 14'h3011;
        prog[11'h405] = 14'h3022;
        prog[11'h406] = 14'h1C22;
        prog[11'h407] = 14'h3033;
        prog[11'h408] = 14'h2010;
        prog[11'h409] = 14'h2C09;
        prog[11'h010] = 14'h3444;
        wait_cycles(3);
        check("w_prefetch_dropped", w_reg, 16'h0000);
        check("pc_after_jump", fetch_addr, 16'h0406);
        wait_cycles(1);
        check("w_target", w_reg, 16'h0022);
        wait_cycles(2);
        check("w_skipped", w_reg, 16'h0022);
        wait_cycles(3);
        check("w_return", w_reg, 16'h0044);
        check("flushes", n_fl, 16'h0004);
    endtask

    task automatic t_port;
        start();
        fmem[7'h05] = 8'hFF;
        prescaler_on_timer = 1'b1;
        prog[0] = 14'h0885;
        prog[1] = 14'h0185;
        prog[2] = 14'h0081;
        prog[3] = 14'h0801;
        prog[4] = 14'h0081;
        prog[5] = 14'h2805;
        wait_cycles(2);
        check("port_from_pins", fmem[7'h05], 16'h003C);
        wait_cycles(1);
        check("port_cleared", fmem[7'h05], 16'h0000);
        check("port_reads", n_prd, 16'h0002);
        wait_cycles(2);
        check("presc_clr_on", n_pc, 16'h0001);
        prescaler_on_timer = 1'b0;
        wait_cycles(1);
        check("presc_clr_off", n_pc, 16'h0001);
    endtask

    // Sleep, call/return, subtract, rotate, swap and a counting skip
    task automatic t_ctl;
        start();
        fmem[7'h20] = 8'h81;
        fmem[7'h21] = 8'h01;
        prog[0] = 14'h0063;
        prog[1] = 14'h2005;
        prog[2] = 14'h0064;
        prog[3] = 14'h2803;
        prog[5] = 14'h3C10;
        prog[6] = 14'h0C20;
        prog[7] = 14'h0E20;
        prog[8] = 14'h0BA1;
        prog[9] = 14'h3099;
        prog[10] = 14'h0008;
        wait_cycles(2);
        check("pd_sleep", powerdown_flag, 16'h0000);
        check("to_sleep", timeout_flag, 16'h0001);
        check("sleep_reqs", n_sl, 16'h0001);
        wait_cycles(3);
        check("w_sub_lit", w_reg, 16'h0010);
        check("c_sub", carry_flag, 16'h0001);
        check("dc_sub", digit_carry_flag, 16'h0001);
        wait_cycles(1);
        check("w_rotate", w_reg, 16'h00C0);
        check("f_rotate_kept", fmem[7'h20], 16'h0081);
        wait_cycles(1);
        check("w_swap", w_reg, 16'h0018);
        wait_cycles(2);
        check("f_dec_skip", fmem[7'h21], 16'h0000);
        check("w_skipped_lit", w_reg, 16'h0018);
        check("z_skip_kept", zero_flag, 16'h0000);
        wait_cycles(3);
        check("pc_return", fetch_addr, 16'h0004);
        check("pd_clrwdt", powerdown_flag, 16'h0001);
        check("wdt_clears", n_wd, 16'h0002);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        pin_level = 8'h3C;
        prescaler_on_timer = 1'b0;
        file_rd_data = 8'h00;
        t_byte();
        t_bits();
        t_branch();
        t_port();
        t_ctl();
        test_done();
    end
endmodule
